// file: hw/pesd_decoder.sv
// Operation
// - event 87/04 counts instruction-queue-full decode stalls
// - 88 mask 01 qualifies executed conditional branches
// - taken needs a type bit, else rejected
// - 88/FF counts every executed near branch
// - 89 same qualifiers, mispredicted branches only
// - 9C/01 counts per-thread undelivered uops
// - A1 counts dispatch cycles on chosen port
// - A2 counts allocation resource stall cycles
// - A3 01/02 pending loads, per-core option
// - A3 04 dispatch stall cycles, per-core option
// - A3 02/04/05/06 only counters 0-3 without SMT
`timescale 1ns/1ns
module pesd_decoder #(
    parameter int NUM_CNT = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pesd_pkg::pesd_pipe_s pipe,
    input wire logic multithreading_enabled
);
    import pesd_pkg::*;

    logic aw_held;
    logic w_held;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [31:0] sel_word;
    logic [31:0] count;
    pesd_sel_s sel;
    logic wr_go;
    logic sel_wr;
    logic cnt_wr;
    logic sel_valid;
    logic [3:0] occ;
    logic [31:0] inc;
    logic [31:0] next_sel;
    logic [31:0] next_count;
    logic [31:0] rd_word;
    logic rd_hit;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                m[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return m;
    endfunction : merge

    assign sel = pesd_sel_s'(sel_word[SEL_W-1:0]);
    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign sel_wr = wr_go && (awaddr_q == OFF_SELECT);
    assign cnt_wr = wr_go && (awaddr_q == OFF_COUNT);
    assign next_sel = merge(sel_word, wdata_q, wstrb_q) & {{(32-SEL_W){1'b0}}, {SEL_W{1'b1}}};
    assign next_count = merge(count, wdata_q, wstrb_q);

    // qualifier legality; software is trusted for nothing, a bad mix counts zero
    always_comb
    begin
        logic [7:0] um;
        um = sel.umask;
        sel_valid = 1'b1;
        if ({5'h0, sel.idx} >= NUM_CNT[7:0])
        begin
            sel_valid = 1'b0;
        end
        unique case (sel.event_num)
            EV_QUEUE_FULL: sel_valid = sel_valid && (um == UM_QUEUE_FULL);
            EV_BR_EXEC, EV_BR_MISP:
            begin
                if (um[BIT_TAKEN] && !(|um[5:0]))
                begin
                    sel_valid = 1'b0;
                end
                if (um[BIT_NONTAKEN] && !um[BIT_COND])
                begin
                    sel_valid = 1'b0;
                end
                if (!um[BIT_NONTAKEN] && !um[BIT_TAKEN])
                begin
                    sel_valid = 1'b0;
                end
            end
            EV_UNDLV: sel_valid = sel_valid && (um == UM_UNDLV);
            EV_PORT: sel_valid = sel_valid && (um inside {UM_P0, UM_P1, UM_P2, UM_P3, UM_P4, UM_P5});
            EV_RSTALL: sel_valid = sel_valid && (um inside {UM_STALL_ANY, UM_STALL_STATION, UM_STALL_STORE,
                UM_STALL_REORDER});
            EV_PEND:
            begin
                if (!(um inside {UM_PD_L2, UM_PD_MEM, UM_PD_NOEX, UM_PD_ST_L2, UM_PD_ST_MEM}))
                begin
                    sel_valid = 1'b0;
                end
                if ((um inside {UM_PD_MEM, UM_PD_NOEX, UM_PD_ST_L2, UM_PD_ST_MEM}) && !multithreading_enabled
                    && (sel.idx > RESTRICT_MAX_IDX))
                begin
                    sel_valid = 1'b0;
                end
            end
            default: sel_valid = 1'b0;
        endcase
    end

    // occurrences of the selected condition in this cycle
    always_comb
    begin
        logic [7:0] um;
        logic dir_hit;
        logic l2;
        logic mem;
        logic nx;
        um = sel.umask;
        dir_hit = (um[BIT_TAKEN] && pipe.br_taken) || (um[BIT_NONTAKEN] && !pipe.br_taken);
        l2 = sel.per_core_count_enable ? |pipe.l2_pend : pipe.l2_pend[0];
        mem = sel.per_core_count_enable ? |pipe.mem_pend : pipe.mem_pend[0];
        nx = sel.per_core_count_enable ? |pipe.no_exec : pipe.no_exec[0];
        occ = 4'h0;
        unique case (sel.event_num)
            EV_QUEUE_FULL: occ = {3'h0, pipe.queue_full};
            EV_BR_EXEC: occ = {3'h0, pipe.br_valid && (|(um[5:0] & pipe.br_type)) && dir_hit};
            EV_BR_MISP: occ = {3'h0, pipe.br_valid && pipe.br_misp && (|(um[5:0] & pipe.br_type)) && dir_hit};
            EV_UNDLV: occ = {1'b0, pipe.undelivered};
            EV_PORT:
            begin
                unique case (um)
                    UM_P0: occ = {3'h0, pipe.port_disp[0]};
                    UM_P1: occ = {3'h0, pipe.port_disp[1]};
                    UM_P2: occ = {3'h0, pipe.port_disp[2]};
                    UM_P3: occ = {3'h0, pipe.port_disp[3]};
                    UM_P4: occ = {3'h0, pipe.port_disp[4]};
                    UM_P5: occ = {3'h0, pipe.port_disp[5]};
                    default: occ = 4'h0;
                endcase
            end
            EV_RSTALL:
            begin
                unique case (um)
                    UM_STALL_ANY: occ = {3'h0, pipe.stall_any};
                    UM_STALL_STATION: occ = {3'h0, pipe.stall_station};
                    UM_STALL_STORE: occ = {3'h0, pipe.stall_store};
                    UM_STALL_REORDER: occ = {3'h0, pipe.stall_reorder};
                    default: occ = 4'h0;
                endcase
            end
            EV_PEND:
            begin
                unique case (um)
                    UM_PD_L2: occ = {3'h0, l2};
                    UM_PD_MEM: occ = {3'h0, mem};
                    UM_PD_NOEX: occ = {3'h0, nx};
                    UM_PD_ST_L2: occ = {3'h0, l2 && nx};
                    UM_PD_ST_MEM: occ = {3'h0, mem && nx};
                    default: occ = 4'h0;
                endcase
            end
            default: occ = 4'h0;
        endcase
    end

    // a nonzero cmask turns the count into cycles meeting the threshold
    assign inc = (sel.cmask != 8'h00) ? {31'h0, {4'h0, occ} >= sel.cmask} : {28'h0, occ};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count <= COUNT_RST;
        end
        else if (cnt_wr)
        begin
            // a software load wins over this cycle's increment
            count <= next_count;
        end
        else if (sel.en && sel_valid)
        begin
            count <= count + inc;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sel_word <= SELECT_RST;
        end
        else if (sel_wr)
        begin
            sel_word <= next_sel;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            s_axi_awready <= 1'b1;
            awaddr_q <= 12'h000;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
            awaddr_q <= {s_axi_awaddr[11:2], 2'h0};
        end
        else if (wr_go)
        begin
            aw_held <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held <= 1'b0;
            s_axi_wready <= 1'b1;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        else if (wr_go)
        begin
            w_held <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            // status is read-only, so a write there is a decode error too
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (sel_wr || cnt_wr) ? RESP_OKAY : RESP_DECERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_comb
    begin
        rd_hit = 1'b1;
        unique case ({s_axi_araddr[11:2], 2'h0})
            OFF_SELECT: rd_word = sel_word;
            OFF_COUNT: rd_word = count;
            OFF_STATUS: rd_word = {30'h0, sel.en && sel_valid, sel_valid};
            default:
            begin
                rd_word = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic plain;
    assign plain = sel.en && sel_valid && (sel.cmask == 8'h00) && !cnt_wr;

    AST_QUEUE_FULL: assert property (
        plain && sel.event_num == 8'h87 && sel.umask == 8'h04 && pipe.queue_full
        |=> count == $past(count) + 32'h1) else $error("queue full stall not counted");
    AST_COND_NT: assert property (
        plain && sel.event_num == 8'h88 && sel.umask == 8'h41 && pipe.br_valid
        && pipe.br_type[0] && !pipe.br_taken |=> count == $past(count) + 32'h1)
        else $error("conditional branch not counted");
    AST_TAKEN_ALONE: assert property (
        sel.event_num == 8'h88 && sel.umask == 8'h80 && !cnt_wr
        |-> !sel_valid ##1 (cnt_wr || count == $past(count))) else $error("taken alone accepted");
    AST_ALL_EXEC: assert property (
        plain && sel.event_num == 8'h88 && sel.umask == 8'hff && pipe.br_valid
        |=> count == $past(count) + 32'h1) else $error("executed branch missed");
    AST_MISP_ONLY: assert property (
        plain && sel.event_num == 8'h89 && sel.umask == 8'hff && !pipe.br_misp
        |=> $stable(count)) else $error("predicted branch counted as miss");
    AST_UNDLV: assert property (
        plain && sel.event_num == 8'h9c && sel.umask == 8'h01
        |=> count == $past(count) + {29'h0, $past(pipe.undelivered)}) else $error("undelivered sum wrong");
    AST_PORT3: assert property (
        plain && sel.event_num == 8'ha1 && sel.umask == 8'h30 && pipe.port_disp[3]
        |=> count == $past(count) + 32'h1) else $error("port dispatch missed");
    AST_REORDER: assert property (
        plain && sel.event_num == 8'ha2 && sel.umask == 8'h10 && !pipe.stall_reorder
        |=> $stable(count)) else $error("reorder stall counted while clear");
    AST_L2_ANY: assert property (
        plain && sel.event_num == 8'ha3 && sel.umask == 8'h01
        && sel.per_core_count_enable && pipe.l2_pend == 2'h2 |=> count == $past(count) + 32'h1)
        else $error("sibling pending load not counted");
    AST_NOEX_OWN: assert property (
        plain && sel.event_num == 8'ha3 && sel.umask == 8'h04
        && !sel.per_core_count_enable && pipe.no_exec == 2'h2 |=> $stable(count))
        else $error("sibling stall counted per thread");
    AST_RESTRICT: assert property (
        sel.event_num == 8'ha3 && sel.umask == 8'h02 && !multithreading_enabled
        && sel.idx == 3'h4 && !cnt_wr |-> !sel_valid ##1 (cnt_wr || $stable(count)))
        else $error("restricted mask on high counter");
    AST_CMASK: assert property (
        sel.en && sel_valid && sel.cmask == 8'h02 && !cnt_wr
        && sel.event_num == 8'h9c && pipe.undelivered == 3'h3 |=> count == $past(count) + 32'h1)
        else $error("threshold count wrong");

    COV_BR: cover property (plain && sel.event_num == 8'h88 && pipe.br_valid ##1 count != $past(count));
    COV_MISP: cover property (plain && sel.event_num == 8'h89 && pipe.br_misp && pipe.br_valid);
    COV_PEND: cover property (sel.en && sel_valid && sel.event_num == 8'ha3 && sel.umask == 8'h05 && occ != 4'h0);
    COV_DECERR: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
endmodule : pesd_decoder

// file: hw/pesd_pkg.sv
package pesd_pkg;
    localparam logic [7:0] EV_QUEUE_FULL = 8'h87;
    localparam logic [7:0] EV_BR_EXEC = 8'h88;
    localparam logic [7:0] EV_BR_MISP = 8'h89;
    localparam logic [7:0] EV_UNDLV = 8'h9c;
    localparam logic [7:0] EV_PORT = 8'ha1;
    localparam logic [7:0] EV_RSTALL = 8'ha2;
    localparam logic [7:0] EV_PEND = 8'ha3;
    localparam logic [7:0] UM_QUEUE_FULL = 8'h04;
    localparam logic [7:0] UM_UNDLV = 8'h01;
    localparam logic [7:0] UM_ALL = 8'hff;
    localparam int BIT_COND = 0;
    localparam int BIT_NONTAKEN = 6;
    localparam int BIT_TAKEN = 7;
    localparam logic [7:0] UM_P0 = 8'h01;
    localparam logic [7:0] UM_P1 = 8'h02;
    localparam logic [7:0] UM_P2 = 8'h0c;
    localparam logic [7:0] UM_P3 = 8'h30;
    localparam logic [7:0] UM_P4 = 8'h40;
    localparam logic [7:0] UM_P5 = 8'h80;
    localparam logic [7:0] UM_STALL_ANY = 8'h01;
    localparam logic [7:0] UM_STALL_STATION = 8'h04;
    localparam logic [7:0] UM_STALL_STORE = 8'h08;
    localparam logic [7:0] UM_STALL_REORDER = 8'h10;
    localparam logic [7:0] UM_PD_L2 = 8'h01;
    localparam logic [7:0] UM_PD_MEM = 8'h02;
    localparam logic [7:0] UM_PD_NOEX = 8'h04;
    localparam logic [7:0] UM_PD_ST_L2 = 8'h05;
    localparam logic [7:0] UM_PD_ST_MEM = 8'h06;
    localparam logic [2:0] RESTRICT_MAX_IDX = 3'h3;
    localparam logic [11:0] OFF_SELECT = 12'h000;
    localparam logic [11:0] OFF_COUNT = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam int SEL_W = 29;
    localparam logic [31:0] SELECT_RST = 32'h0000_0000;
    localparam logic [31:0] COUNT_RST = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // bit 0 of each pair is this thread, bit 1 the sibling thread
    typedef struct packed {
        logic br_valid;
        logic [5:0] br_type;
        logic br_taken;
        logic br_misp;
        logic queue_full;
        logic [2:0] undelivered;
        logic [5:0] port_disp;
        logic stall_any;
        logic stall_station;
        logic stall_store;
        logic stall_reorder;
        logic [1:0] l2_pend;
        logic [1:0] mem_pend;
        logic [1:0] no_exec;
    } pesd_pipe_s;

    typedef struct packed {
        logic [2:0] idx;
        logic en;
        logic per_core_count_enable;
        logic [7:0] cmask;
        logic [7:0] umask;
        logic [7:0] event_num;
    } pesd_sel_s;
endpackage : pesd_pkg

// file: tb/pesd_decoder_tb.sv
`timescale 1ns/1ns
module pesd_decoder_tb;
    import pesd_pkg::*;
    localparam int NCNT = 6;
    localparam logic [7:0] PMASK [6] = '{UM_P0, UM_P1, UM_P2, UM_P3, UM_P4, UM_P5};
    localparam logic [7:0] RMASK [4] = '{UM_STALL_ANY, UM_STALL_STATION, UM_STALL_STORE, UM_STALL_REORDER};
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, mt, run;
    logic awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, exp_cnt, rnd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, eb;
    logic [32:0] cur;
    logic [65:0] er;
    pesd_pipe_s pipe;
    logic [65:0] rq [$];
    logic [1:0] bq [$];
    logic [32:0] cfgs [$];
    int err_total, checked;

    pesd_decoder #(.NUM_CNT(NCNT)) dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pipe(pipe),
        .multithreading_enabled(mt)
    );
    pesd_pipe_model core (.aclk(aclk), .run(run), .pipe(pipe));

    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic tally_and_finish();
        err_total += rq.size() + bq.size();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    task automatic hang();
        err_total++;
        $display("CHECK FAILED %0t bus handshake never completed", $time);
        tally_and_finish();
    endtask : hang

    function automatic logic legal_of(input logic [32:0] c);
        logic [7:0] um;
        um = c[15:8];
        if (c[28:26] >= NCNT)
            return 1'b0;
        case (c[7:0])
            EV_QUEUE_FULL: return um == UM_QUEUE_FULL;
            EV_BR_EXEC, EV_BR_MISP: return !(um[7] && um[5:0] == 0) && !(um[6] && !um[0]) && (um[7] || um[6]);
            EV_UNDLV: return um == UM_UNDLV;
            EV_PORT: return um inside {PMASK};
            EV_RSTALL: return um inside {RMASK};
            EV_PEND: return um inside {UM_PD_L2, UM_PD_MEM, UM_PD_NOEX, UM_PD_ST_L2, UM_PD_ST_MEM}
                && !(um != UM_PD_L2 && !c[32] && c[28:26] > 3);
            default: return 1'b0;
        endcase
    endfunction : legal_of

    function automatic logic [31:0] inc_of(input pesd_pipe_s p, input logic [32:0] c);
        logic [7:0] um;
        logic [7:0] cm;
        logic [3:0] occ;
        logic l2, mm, nx;
        um = c[15:8];
        cm = c[23:16];
        occ = 4'h0;
        if (!legal_of(c) || !c[25])
            return 32'h0;
        l2 = c[24] ? |p.l2_pend : p.l2_pend[0];
        mm = c[24] ? |p.mem_pend : p.mem_pend[0];
        nx = c[24] ? |p.no_exec : p.no_exec[0];
        case (c[7:0])
            EV_QUEUE_FULL: occ = {3'h0, p.queue_full};
            EV_BR_EXEC, EV_BR_MISP: occ = {3'h0, p.br_valid && (um[5:0] & p.br_type) != 0
                && (um[7] && p.br_taken || um[6] && !p.br_taken) && (c[7:0] == EV_BR_EXEC || p.br_misp)};
            EV_UNDLV: occ = {1'b0, p.undelivered};
            EV_PORT:
                foreach (PMASK[i])
                    if (um == PMASK[i])
                        occ = {3'h0, p.port_disp[i]};
            EV_RSTALL: occ = {3'h0, um == UM_STALL_ANY && p.stall_any || um == UM_STALL_STATION && p.stall_station
                || um == UM_STALL_STORE && p.stall_store || um == UM_STALL_REORDER && p.stall_reorder};
            EV_PEND: occ = {3'h0, um == UM_PD_L2 && l2 || um == UM_PD_MEM && mm || um == UM_PD_NOEX && nx
                || um == UM_PD_ST_L2 && l2 && nx || um == UM_PD_ST_MEM && mm && nx};
            default: occ = 4'h0;
        endcase
        return cm == 0 ? {28'h0, occ} : 32'({4'h0, occ} >= cm);
    endfunction : inc_of

    task automatic add(input logic [7:0] ev, input logic [7:0] um, input logic [7:0] cm, input logic [2:0] idx,
        input logic [2:0] f);
        cfgs.push_back({f[2], 3'h0, idx, f[1], f[0], cm, um, ev});
    endtask : add

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        int n;
        bit done;
        @(posedge aclk);
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        done = 0;
        while (!done)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            done = (bvalid === 1'b1);
            n++;
            if (n > 40)
                hang();
        end
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] d, input logic [1:0] r);
        int n;
        bit done;
        @(posedge aclk);
        rq.push_back({r, m, d & m});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        done = 0;
        while (!done)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
            done = (rvalid === 1'b1);
            n++;
            if (n > 40)
                hang();
        end
        rready <= 1'b0;
    endtask : rd

    // the expected count follows the pipe exactly as the counter samples it
    always @(posedge aclk)
    begin
        exp_cnt += inc_of(pipe, cur);
        if (bvalid === 1'b1 && bready)
        begin
            eb = bq.pop_front();
            checked++;
            if (bresp !== eb)
            begin
                err_total++;
                $display("CHECK FAILED %0t write resp %h expected %h", $time, bresp, eb);
            end
        end
        if (rvalid === 1'b1 && rready)
        begin
            er = rq.pop_front();
            checked++;
            if ((rdata & er[63:32]) !== er[31:0] || rresp !== er[65:64])
            begin
                err_total++;
                $display("CHECK FAILED %0t read %h resp %h expected %h %h", $time, rdata, rresp, er[31:0], er[65:64]);
            end
        end
    end

    initial
    begin
        void'($urandom(32'h478a6530));
        {aresetn, awvalid, wvalid, bready, arvalid, rready, mt, run} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        err_total = 0;
        checked = 0;
        exp_cnt = '0;
        cur = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_SELECT, 32'hffff_ffff, SELECT_RST, RESP_OKAY);
        rd(OFF_COUNT, 32'hffff_ffff, COUNT_RST, RESP_OKAY);
        wr(OFF_STATUS, 32'h0000_0003, 4'hf, RESP_DECERR);
        rd(OFF_STATUS, 32'hffff_ffff, 32'h0, RESP_OKAY);
        wr(12'h00c, 32'hffff_ffff, 4'hf, RESP_DECERR);
        rd(12'h00c, 32'hffff_ffff, 32'h0, RESP_DECERR);
        rd(OFF_SELECT, 32'hffff_ffff, SELECT_RST, RESP_OKAY);
        rnd = $urandom;
        wr(OFF_COUNT, rnd, 4'h5, RESP_OKAY);
        rd(OFF_COUNT, 32'hffff_ffff, rnd & 32'h00ff_00ff, RESP_OKAY);
        add(EV_QUEUE_FULL, UM_QUEUE_FULL, 8'h0, 3'h0, 3'b010);
        add(EV_QUEUE_FULL, 8'h01, 8'h0, 3'h0, 3'b010);
        add(EV_BR_EXEC, 8'h81, 8'h0, 3'h1, 3'b010);
        add(EV_BR_EXEC, 8'h41, 8'h0, 3'h2, 3'b010);
        add(EV_BR_EXEC, 8'hbe, 8'h0, 3'h0, 3'b010);
        add(EV_BR_EXEC, 8'h3e, 8'h0, 3'h0, 3'b010);
        add(EV_BR_EXEC, 8'h80, 8'h0, 3'h0, 3'b010);
        add(EV_BR_EXEC, 8'h42, 8'h0, 3'h0, 3'b010);
        add(EV_BR_EXEC, UM_ALL, 8'h0, 3'h0, 3'b010);
        add(EV_BR_MISP, UM_ALL, 8'h0, 3'h0, 3'b010);
        add(EV_BR_MISP, 8'h41, 8'h0, 3'h0, 3'b010);
        add(EV_BR_MISP, 8'hb8, 8'h0, 3'h0, 3'b010);
        add(EV_BR_MISP, 8'h44, 8'h0, 3'h0, 3'b010);
        add(EV_UNDLV, UM_UNDLV, 8'h0, 3'h0, 3'b010);
        add(EV_UNDLV, UM_UNDLV, 8'h3, 3'h0, 3'b010);
        foreach (PMASK[i])
            add(EV_PORT, PMASK[i], 8'h0, 3'h0, 3'b010);
        foreach (RMASK[i])
            add(EV_RSTALL, RMASK[i], 8'h0, 3'h0, 3'b010);
        add(EV_PEND, UM_PD_L2, 8'h0, 3'h5, 3'b010);
        add(EV_PEND, UM_PD_MEM, 8'h0, 3'h3, 3'b011);
        add(EV_PEND, UM_PD_NOEX, 8'h0, 3'h0, 3'b010);
        add(EV_PEND, UM_PD_NOEX, 8'h0, 3'h5, 3'b111);
        add(EV_PEND, UM_PD_ST_L2, 8'h0, 3'h4, 3'b010);
        add(EV_PEND, UM_PD_ST_MEM, 8'h2, 3'h2, 3'b011);
        add(EV_PEND, UM_PD_MEM, 8'h0, 3'h4, 3'b110);
        add(EV_PORT, UM_P0, 8'h0, 3'h6, 3'b010);
        add(EV_QUEUE_FULL, UM_QUEUE_FULL, 8'h0, 3'h0, 3'b000);
        foreach (cfgs[k])
        begin
            mt <= cfgs[k][32];
            wr(OFF_SELECT, cfgs[k][31:0], 4'hf, RESP_OKAY);
            rd(OFF_SELECT, 32'hffff_ffff, cfgs[k][31:0], RESP_OKAY);
            rd(OFF_STATUS, 32'hffff_ffff, {30'h0, legal_of(cfgs[k]) && cfgs[k][25], legal_of(cfgs[k])}, RESP_OKAY);
            wr(OFF_COUNT, 32'h0, 4'hf, RESP_OKAY);
            cur = cfgs[k];
            exp_cnt = '0;
            run <= 1'b1;
            repeat (40) @(posedge aclk);
            run <= 1'b0;
            repeat (2) @(posedge aclk);
            rd(OFF_COUNT, 32'hffff_ffff, exp_cnt, RESP_OKAY);
        end
        repeat (2) @(posedge aclk);
        tally_and_finish();
    end
endmodule : pesd_decoder_tb

// file: tb/pesd_pipe_model.sv
`timescale 1ns/1ns
module pesd_pipe_model
    import pesd_pkg::*;
(
    input wire logic aclk,
    input wire logic run,
    output pesd_pkg::pesd_pipe_s pipe
);
    localparam int PIPE_W = $bits(pesd_pipe_s);
    pesd_pipe_s next_pipe;

    // a branch carries one type only; type bits stay noisy while no branch is valid
    always @(posedge aclk)
    begin
        if (run)
        begin
            next_pipe = pesd_pipe_s'(PIPE_W'({$urandom, $urandom}));
            if (next_pipe.br_valid)
                next_pipe.br_type = 6'h01 << ($urandom % 6);
            pipe <= next_pipe;
        end
        else
            pipe <= '0;
    end
endmodule : pesd_pipe_model
